// ### hdl/loop_bist.sv
// Loopback selection and packet-framed PRBS self-test for a 10/100 PHY.
// Assumes MAC nibbles and line-side nibbles share the core clock and
// that management accesses arrive already decoded from the serial port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Control bits 3:0 pick near-end loop point
// - Basic mode bit 14 loops MAC tx
// - Control bit 0 enables coding input loop
// - Control bit 1 enables coding output loop
// - Coding loops bypass all signal processing
// - Control bit 2 loops whole digital path
// - Control bit 3 loops after analog front
// - Control bit 4 retransmits received data
// - Reverse loop ignores all MAC data
// - Generator frames PRBS into packets, gaps
// - Packet length from 0x1C bits 10:0
// - Gap length from 0x1B bits 7:0
// - 15-bit PRBS stepped on payload only, independent generator
// - Checker compares received data to PRBS
// - Error byte count in 0x1B upper byte
// - Lock and sync readable at 0x16
// - Continuous mode counter wraps to zero
// - Writing 0x1B bit 15 latches, clears counter
// - MII loop via 0x00, others 0x16
// - Loops work at both speeds
module loop_bist (
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_n_in,
  // Management register port
  input  wire logic                   mgmt_wr_in,
  input  wire logic [4:0]             mgmt_addr_in,
  input  wire logic [15:0]            mgmt_wdata_in,
  output logic      [15:0]            mgmt_rdata_out,
  // MAC side
  input  wire loop_bist_pkg::nibble_s mac_tx_in,
  output logic                        mac_tx_ready_out,
  output loop_bist_pkg::nibble_s      mac_rx_out,
  // Line side
  output loop_bist_pkg::nibble_s      line_tx_out,
  input  wire logic                   line_tx_ready_in,
  input  wire loop_bist_pkg::nibble_s line_rx_in,
  output loop_bist_pkg::loop_point_e  loop_point_out
);
  import loop_bist_pkg::*;
  // ****************************************************************
  // Register state
  // ****************************************************************
  logic        mii_loop_reg;       // Basic mode control loop bit
  logic [15:0] ctrl_reg;           // Loopback and self-test control
  logic [7:0]  gap_reg;            // Inter-packet gap in bytes
  logic [10:0] len_reg;            // Packet length in bytes
  logic [7:0]  err_cnt_reg;        // Running error byte count
  logic [7:0]  err_latch_reg;      // Count captured for reading
  // ****************************************************************
  // Data path state
  // ****************************************************************
  nibble_s     mac_rx_reg;         // Registered toward the MAC
  nibble_s     line_tx_reg;        // Registered toward the line
  // ****************************************************************
  // Generator state
  // ****************************************************************
  gen_state_e  gen_state_reg;
  gen_state_e  gen_state_next;
  logic [14:0] gen_lfsr_reg;       // Generator sequence state
  logic [11:0] gen_cnt_reg;        // Nibbles left in packet or gap
  logic [11:0] gen_cnt_next;
  // ****************************************************************
  // Checker state
  // ****************************************************************
  logic [14:0] chk_lfsr_reg;       // Local copy built from rx data
  logic [3:0]  good_run_reg;       // Clean nibbles since last miss
  logic        locked_reg;         // Checker has followed the stream
  logic        synced_reg;         // Last nibble matched
  logic        half_reg;           // Second nibble of a byte pending
  logic        byte_err_reg;       // First nibble of byte mismatched
  // ****************************************************************
  // Decode functions
  // ****************************************************************
  // One bit step of x^15 + x^14 + 1
  function automatic logic [14:0] prbs_bit(input logic [14:0] s);
    prbs_bit = {s[13:0], s[14] ^ s[13]};
  endfunction
  // Four steps; the nibble is the four new bits, oldest in bit 3
  function automatic logic [14:0] prbs_nib(input logic [14:0] s);
    logic [14:0] t;
    t = s;
    for (int i = 0; i < 4; i++) begin
      t = prbs_bit(t);
    end
    prbs_nib = t;
  endfunction
  // Byte count to nibble count, at least one nibble
  function automatic logic [11:0] nib_len(input logic [10:0] b);
    nib_len = (b == 11'h000) ? 12'h001 : {b, 1'b0};
  endfunction
  // ****************************************************************
  // Loop selection decode
  // ****************************************************************
  wire         loop_pcs  = ctrl_reg[pcs_in_bit]
                         | ctrl_reg[pcs_out_bit];
  wire         loop_dig  = ctrl_reg[digital_bit];
  wire         loop_ana  = ctrl_reg[analog_bit];
  wire         loop_rev  = ctrl_reg[reverse_bit];
  wire         loop_mii  = mii_loop_reg;
  wire         gen_on    = ctrl_reg[gen_enable_bit];
  wire         chk_on    = ctrl_reg[chk_enable_bit];
  wire         cont_mode = ctrl_reg[continuous_bit];
  // Point sent to the analog and digital stages
  assign loop_point_out = loop_ana ? point_analog :
                          loop_dig ? point_digital : point_none;
  // ****************************************************************
  // Transmit source selection and FIFO
  // ****************************************************************
  wire [14:0]  gen_step   = prbs_nib(gen_lfsr_reg);
  wire [3:0]   gen_nib    = gen_step[3:0];
  wire         gen_active = gen_on & (gen_state_reg == gen_pkt);
  nibble_s     src_word;          // Word offered to the FIFO
  nibble_s     fifo_word;         // Word leaving the FIFO
  wire         fifo_in_ready;
  wire         fifo_out_valid;
  wire         fifo_out_ready;
  wire         src_valid;

  // Reverse loop drops MAC data and outranks self-test; otherwise self-test owns the line when on
  assign src_word = loop_rev ? line_rx_in :
                    gen_on   ? nibble_s'{gen_active, gen_nib} :
                    loop_mii ? nibble_s'{1'b0, 4'h0} :
                               mac_tx_in;
  // Generator and reverse path push every cycle, MAC only on enable
  assign src_valid = loop_rev | gen_on | (mac_tx_in.en & ~loop_mii);
  // MAC stalls while the FIFO is full, never in MII or reverse loop or while self-test runs
  assign mac_tx_ready_out = loop_rev | gen_on | loop_mii
                          | fifo_in_ready;
  // Coding loops drain locally so the line never throttles them
  assign fifo_out_ready = line_tx_ready_in | loop_pcs;
  stream_fifo #(
    .WIDTH (5),
    .DEPTH (fifo_depth)
  ) tx_fifo (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (src_word),
    .in_valid_in   (src_valid),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (fifo_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready)
  );

  wire         fifo_pop = fifo_out_valid & fifo_out_ready;
  // ****************************************************************
  // Receive selection toward the MAC
  // ****************************************************************
  nibble_s     rx_sel;
  // MII loop is shallowest; coding loops skip the line entirely
  assign rx_sel = loop_mii ? mac_tx_in :
                  loop_pcs ? (fifo_pop ? fifo_word
                                       : nibble_s'{1'b0, 4'h0}) :
                             line_rx_in;
  // Output registers for both data directions
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mac_rx_reg  <= '0;
      line_tx_reg <= '0;
    end else begin
      mac_rx_reg <= rx_sel;
      // Coding loops keep the line quiet
      if (fifo_pop && !loop_pcs) begin
        line_tx_reg <= fifo_word;
      end else if (line_tx_ready_in || loop_pcs) begin
        line_tx_reg <= '0;
      end
    end
  end
  assign mac_rx_out  = mac_rx_reg;
  assign line_tx_out = line_tx_reg;
  // ****************************************************************
  // Generator packet framing
  // ****************************************************************
  // Counts are in nibbles, two to a byte
  always_comb begin
    gen_state_next = gen_state_reg;
    gen_cnt_next   = gen_cnt_reg;
    unique case (gen_state_reg)
      gen_idle: begin
        // Start with a packet as soon as enabled
        if (gen_on) begin
          gen_state_next = gen_pkt;
          gen_cnt_next   = nib_len(len_reg);
        end
      end
      gen_pkt: begin
        // Count only words the FIFO really took
        if (!gen_on) begin
          gen_state_next = gen_idle;
        end else if (fifo_in_ready) begin
          if (gen_cnt_reg == 12'h001) begin
            gen_state_next = gen_gap;
            gen_cnt_next   = {3'h0, gap_reg, 1'b0};
          end else begin
            gen_cnt_next = gen_cnt_reg - 12'h001;
          end
        end
      end
      gen_gap: begin
        // A zero gap still idles one nibble
        if (!gen_on) begin
          gen_state_next = gen_idle;
        end else if (fifo_in_ready) begin
          if (gen_cnt_reg <= 12'h001) begin
            gen_state_next = gen_pkt;
            gen_cnt_next   = nib_len(len_reg);
          end else begin
            gen_cnt_next = gen_cnt_reg - 12'h001;
          end
        end
      end
    endcase
  end
  // Sequence steps only on payload nibbles the FIFO accepts, so the
  // checker, which sees payload only, follows one unbroken stream.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gen_state_reg <= gen_idle;
      gen_cnt_reg   <= '0;
      gen_lfsr_reg  <= prbs_seed;
    end else begin
      gen_state_reg <= gen_state_next;
      gen_cnt_reg   <= gen_cnt_next;
      if (gen_active && fifo_in_ready && !loop_rev) begin
        gen_lfsr_reg <= gen_step;
      end
    end
  end

  // ****************************************************************
  // Checker
  // ****************************************************************
  // The checker predicts from its own state, built only from what
  // arrives, so it needs no link to the generator.
  wire [14:0]  chk_pred  = prbs_nib(chk_lfsr_reg);
  wire         chk_valid = chk_on & rx_sel.en;
  wire         nib_err   = chk_valid
                         & (chk_pred[3:0] != rx_sel.data);
  // Shift in received bits so a clean stream pulls the copy in line
  wire [14:0]  chk_load  = {chk_lfsr_reg[10:0], rx_sel.data};
  wire         byte_done = chk_valid & half_reg;
  wire         byte_bad  = byte_done & (nib_err | byte_err_reg)
                         & locked_reg;
  wire         latch_wr  = mgmt_wr_in
                         & (mgmt_addr_in == selftest_gap_and_error_count_off)
                         & mgmt_wdata_in[latch_count_bit];

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_lfsr_reg <= prbs_seed;
      good_run_reg <= '0;
      locked_reg   <= 1'b0;
      synced_reg   <= 1'b0;
      half_reg     <= 1'b0;
      byte_err_reg <= 1'b0;
    end else if (!chk_on) begin
      // Disabled checker forgets its lock
      good_run_reg <= '0;
      locked_reg   <= 1'b0;
      synced_reg   <= 1'b0;
      half_reg     <= 1'b0;
      byte_err_reg <= 1'b0;
    end else if (chk_valid) begin
      chk_lfsr_reg <= chk_load;
      synced_reg   <= ~nib_err;
      half_reg     <= ~half_reg;
      byte_err_reg <= half_reg ? 1'b0 : nib_err;
      if (nib_err) begin
        good_run_reg <= '0;
      end else if (good_run_reg != lock_count) begin
        good_run_reg <= good_run_reg + 4'h1;
      end else begin
        locked_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Error byte counter
  // ****************************************************************
  // Latch write copies then clears; an error in that same cycle
  // starts the fresh count at one so it is not lost.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_cnt_reg   <= '0;
      err_latch_reg <= '0;
    end else if (latch_wr) begin
      err_latch_reg <= err_cnt_reg;
      err_cnt_reg   <= byte_bad ? 8'h01 : 8'h00;
    end else if (byte_bad) begin
      if (err_cnt_reg != err_max) begin
        err_cnt_reg <= err_cnt_reg + 8'h01;
      end else if (cont_mode) begin
        err_cnt_reg <= 8'h00;
      end
      // Otherwise hold at the maximum
    end
  end
  // ****************************************************************
  // Register writes
  // ****************************************************************
  wire         wr_bmc  = mgmt_wr_in
                       & (mgmt_addr_in == basic_mode_control_off);
  wire         wr_ctrl = mgmt_wr_in
                       & (mgmt_addr_in == loopback_selftest_control_off);
  wire         wr_gap  = latch_wr | (mgmt_wr_in
                       & (mgmt_addr_in == selftest_gap_and_error_count_off));
  wire         wr_len  = mgmt_wr_in
                       & (mgmt_addr_in == selftest_packet_length_off);
  // Status bits are not stored; they read live from the checker
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mii_loop_reg <= 1'b0;
      ctrl_reg     <= control_reset;
      gap_reg      <= gap_reset;
      len_reg      <= length_reset;
    end else begin
      if (wr_bmc) begin
        mii_loop_reg <= mgmt_wdata_in[mii_loop_bit];
      end
      if (wr_ctrl) begin
        ctrl_reg <= mgmt_wdata_in;
      end
      if (wr_gap) begin
        gap_reg <= mgmt_wdata_in[7:0];
      end
      if (wr_len) begin
        len_reg <= mgmt_wdata_in[10:0];
      end
    end
  end
  // ****************************************************************
  // Register reads
  // ****************************************************************
  logic [15:0] ctrl_view;          // Control with live status bits
  always_comb begin
    ctrl_view                  = ctrl_reg;
    ctrl_view[lock_status_bit] = locked_reg;
    ctrl_view[sync_status_bit] = synced_reg;
  end
  // Unmapped offsets read as zero
  always_comb begin
    unique case (mgmt_addr_in)
      basic_mode_control_off:
        mgmt_rdata_out = {1'b0, mii_loop_reg, 14'h0000};
      loopback_selftest_control_off:
        mgmt_rdata_out = ctrl_view;
      selftest_gap_and_error_count_off:
        mgmt_rdata_out = {err_latch_reg, gap_reg};
      selftest_packet_length_off:
        mgmt_rdata_out = {5'h00, len_reg};
      default:
        mgmt_rdata_out = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

// ### hdl/loop_bist_pkg.sv
// Shared constants and types for the loopback and self-test block.
// Assumes one clock domain and 4-bit nibble data on both sides.
package loop_bist_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [4:0] basic_mode_control_off        = 5'h00;
  localparam logic [4:0] loopback_selftest_control_off = 5'h16;
  localparam logic [4:0] selftest_gap_and_error_count_off = 5'h1b;
  localparam logic [4:0] selftest_packet_length_off    = 5'h1c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int mii_loop_bit     = 14; // In basic mode control
  localparam int pcs_in_bit       = 0;
  localparam int pcs_out_bit      = 1;
  localparam int digital_bit      = 2;
  localparam int analog_bit       = 3;
  localparam int reverse_bit      = 4;
  localparam int gen_enable_bit   = 5;
  localparam int chk_enable_bit   = 6;
  localparam int lock_status_bit  = 9;
  localparam int sync_status_bit  = 10;
  localparam int continuous_bit   = 14;
  localparam int latch_count_bit  = 15;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [15:0] control_reset = 16'h0000;
  localparam logic [7:0]  gap_reset     = 8'h0c;
  localparam logic [10:0] length_reset  = 11'h040;
  localparam logic [14:0] prbs_seed     = 15'h7fff;
  localparam logic [3:0]  lock_count    = 4'hf;
  localparam logic [7:0]  err_max       = 8'hff;
  localparam int          fifo_depth    = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } nibble_s;

  typedef enum logic [1:0] {
    gen_idle = 2'b00,
    gen_pkt  = 2'b01,
    gen_gap  = 2'b10
  } gen_state_e;

  typedef enum logic [1:0] {
    point_none    = 2'b00,
    point_digital = 2'b01,
    point_analog  = 2'b10
  } loop_point_e;

endpackage

// ### hdl/stream_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // Storage words
  logic [AW-1:0]    wr_ptr_reg;      // Next slot to fill
  logic [AW-1:0]    rd_ptr_reg;      // Next slot to drain
  logic [AW:0]      count_reg;       // Words held
  wire              push;
  wire              pop;

  // Full and empty come straight from the count
  assign in_ready_out  = (count_reg != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem[rd_ptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  // ****************************************************************
  // Pointer and count update
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Data array has no reset; only written words are ever read
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// ### verification/loop_bist_props.sv
// Concurrent checks on the loopback and self-test block's ports.
// Assumes one clock domain; bound to loop_bist at the foot of the file.
`timescale 1ns/1ps
`default_nettype none
module loop_bist_props
  import loop_bist_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        mgmt_wr_in,
  input wire logic [4:0]  mgmt_addr_in,
  input wire logic [15:0] mgmt_wdata_in,
  input wire logic [15:0] mgmt_rdata_out,
  input wire nibble_s     mac_tx_in,
  input wire logic        mac_tx_ready_out,
  input wire nibble_s     mac_rx_out,
  input wire nibble_s     line_tx_out,
  input wire logic        line_tx_ready_in,
  input wire nibble_s     line_rx_in,
  input wire loop_point_e loop_point_out
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic        mii_q;   // MII loop bit as last written
  logic [15:0] ctrl_q;  // Last word written to the control register
  wire sel_bmc = mgmt_addr_in == basic_mode_control_off;
  wire sel_ctl = mgmt_addr_in == loopback_selftest_control_off;
  wire sel_gap = mgmt_addr_in == selftest_gap_and_error_count_off;
  wire sel_len = mgmt_addr_in == selftest_packet_length_off;
  // Shadow the writes so modes are known without peeking inside
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mii_q  <= 1'b0;
      ctrl_q <= 16'h0000;
    end else if (mgmt_wr_in) begin
      if (sel_bmc) mii_q <= mgmt_wdata_in[mii_loop_bit];
      if (sel_ctl) ctrl_q <= mgmt_wdata_in;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  ctrl_readback_a: assert property (
    (mgmt_wr_in && sel_ctl) ##1 sel_ctl |->
    mgmt_rdata_out[6:0] == $past(mgmt_wdata_in[6:0]))
    else $error("control readback wrong");
  mii_readback_a: assert property (
    (mgmt_wr_in && sel_bmc) ##1 sel_bmc |->
    mgmt_rdata_out == ($past(mgmt_wdata_in) & 16'h4000))
    else $error("basic mode readback wrong");
  gap_readback_a: assert property (
    (mgmt_wr_in && sel_gap) ##1 sel_gap |->
    mgmt_rdata_out[7:0] == $past(mgmt_wdata_in[7:0]))
    else $error("gap readback wrong");
  len_readback_a: assert property (
    (mgmt_wr_in && sel_len) ##1 sel_len |->
    mgmt_rdata_out[10:0] == $past(mgmt_wdata_in[10:0]))
    else $error("length readback wrong");
  unmapped_zero_a: assert property (
    !(sel_bmc || sel_ctl || sel_gap || sel_len) |-> mgmt_rdata_out == 0)
    else $error("unmapped read not zero");
  digital_point_a: assert property (
    ctrl_q[3:2] == 2'b01 |-> loop_point_out == point_digital)
    else $error("digital loop point not shown");
  analog_point_a: assert property (
    ctrl_q[3] |-> loop_point_out == point_analog)
    else $error("analog loop point not shown");
  mii_echo_a: assert property (
    mii_q && ctrl_q[5:0] == 6'h00 && mac_tx_in.en && mac_tx_ready_out
    |=> mac_rx_out == $past(mac_tx_in))
    else $error("MII loop did not echo");
  reverse_ready_a: assert property (
    ctrl_q[4] |-> mac_tx_ready_out)
    else $error("MAC stalled in reverse loop");
endmodule
bind loop_bist loop_bist_props i_props (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .mgmt_wr_in(mgmt_wr_in), .mgmt_addr_in(mgmt_addr_in),
  .mgmt_wdata_in(mgmt_wdata_in), .mgmt_rdata_out(mgmt_rdata_out),
  .mac_tx_in(mac_tx_in), .mac_tx_ready_out(mac_tx_ready_out),
  .mac_rx_out(mac_rx_out), .line_tx_out(line_tx_out),
  .line_tx_ready_in(line_tx_ready_in), .line_rx_in(line_rx_in),
  .loop_point_out(loop_point_out));
`default_nettype wire

// ### verification/mac_model.sv
// Behavioural MAC on the nibble interface of the loopback block.
// Assumes a one-cycle send pulse from the bench while the model is idle.
`timescale 1ns/1ps
`default_nettype none
module mac_model
  import loop_bist_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       send_in,
  input  wire logic [3:0] data_in,
  input  wire logic       tx_ready_in,
  input  wire nibble_s    rx_in,
  output nibble_s         tx_out,
  output logic [3:0]      rx_last_out,
  output logic [7:0]      rx_cnt_out
);
  // Hold a nibble until taken; released data shows its inverse so a
  // stale value can never pass for a fresh one
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_out      <= '0;
      rx_last_out <= 4'h0;
      rx_cnt_out  <= 8'h00;
    end else begin
      if (tx_out.en && tx_ready_in) tx_out <= {1'b0, ~tx_out.data};
      if (send_in) tx_out <= {1'b1, data_in};
      if (rx_in.en) begin
        rx_last_out <= rx_in.data;
        rx_cnt_out  <= rx_cnt_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_loop_bist.sv
// Self-checking bench for the loopback and self-test block.
// Assumes the bench stands on the line side and loops it when asked.
`timescale 1ns/1ps
`default_nettype none
module tb_loop_bist;
  import loop_bist_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, send = 0, rdy = 1, err = 0;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [3:0]  sdata = 4'h0, rx_last, l_last;
  logic [7:0]  rx_cnt, l_cnt = 0;
  nibble_s     mtx, mrx, ltx, lrx = '0, ldrv = '0;
  logic        mrdy;
  loop_point_e lpt;
  int mismatches = 0, n_compared = 0, cyc = 0, b0, b1;
  loop_bist i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .mgmt_wr_in(wr),
    .mgmt_addr_in(addr), .mgmt_wdata_in(wdata), .mgmt_rdata_out(rdata),
    .mac_tx_in(mtx), .mac_tx_ready_out(mrdy), .mac_rx_out(mrx),
    .line_tx_out(ltx), .line_tx_ready_in(rdy), .line_rx_in(lrx),
    .loop_point_out(lpt));
  mac_model i_mac (.core_clk_in(clk), .rst_n_in(rst_n), .send_in(send),
    .data_in(sdata), .tx_ready_in(mrdy), .rx_in(mrx), .tx_out(mtx),
    .rx_last_out(rx_last), .rx_cnt_out(rx_cnt));
  initial forever #25 clk = ~clk;
  // Line side: loop back when a loop point is set, optional corruption
  always @(posedge clk) begin
    lrx <= (lpt != point_none) ? {ltx.en, ltx.data ^ {4{err}}} : ldrv;
    if (ltx.en === 1'b1) begin
      l_cnt  <= l_cnt + 8'h01;
      l_last <= ltx.data;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  // Read compare under a mask; reads are combinational from the address
  task automatic rreg(input logic [4:0] a, input logic [15:0] m, e);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 chk(rdata & m, e);
  endtask
  task automatic mac_send(input logic [3:0] d);
    @(posedge clk);
    send <= 1; sdata <= d;
    @(posedge clk);
    send <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    // ****************************************************************
    // Reset values and register map
    // ****************************************************************
    rreg(5'h16, 16'hffff, control_reset);
    rreg(5'h1b, 16'h00ff, 16'h000c);
    rreg(5'h1c, 16'h07ff, 16'h0040);
    rreg(5'h05, 16'hffff, 16'h0000);
    wreg(5'h00, 16'hffff);
    rreg(5'h00, 16'hffff, 16'h4000);
    wreg(5'h16, 16'h0604);
    rreg(5'h16, 16'h067f, 16'h0004);
    chk(16'(lpt), 16'(point_digital));
    wreg(5'h16, 16'h0008);
    #1 chk(16'(lpt), 16'(point_analog));
    $display("test registers done");
    // MII loop with the line stalled: echo is immediate, line stays idle
    wreg(5'h16, 16'h0000);
    rdy <= 0; b0 = rx_cnt; b1 = l_cnt;
    for (int i = 0; i < 4; i++) mac_send(4'(i + 3));
    chk(16'(rx_cnt - b0), 16'h0004);
    chk(16'(rx_last), 16'h0006);
    rdy <= 1;
    repeat (8) @(posedge clk);
    chk(16'(l_cnt - b1), 16'h0000);
    $display("test mii loop done");
    // Both coding loops: data returns to the MAC, line stays quiet
    wreg(5'h00, 16'h0000);
    for (int b = 0; b < 2; b++) begin
      wreg(5'h16, 16'(1 << b));
      b1 = l_cnt;
      mac_send(4'(9 + b));
      repeat (4) @(posedge clk);
      chk(16'(rx_last), 16'(9 + b));
      chk(16'(l_cnt - b1), 16'h0000);
    end
    $display("test coding loops done");
    // Reverse loop: line data goes back out, MAC data is dropped
    wreg(5'h16, 16'h0010);
    b1 = l_cnt;
    mac_send(4'h2);
    @(posedge clk) ldrv <= {1'b1, 4'hd};
    @(posedge clk) ldrv <= {1'b0, 4'h2};
    repeat (6) @(posedge clk);
    chk(16'(l_cnt - b1), 16'h0001);
    chk(16'(l_last), 16'h000d);
    $display("test reverse loop done");
    // Self-test over the digital loop: lock, clean count, saturation
    wreg(5'h1c, 16'h0001);
    wreg(5'h1b, 16'h0001);
    wreg(5'h16, 16'h0064);
    repeat (200) @(posedge clk);
    rreg(5'h16, 16'h0200, 16'h0200);
    wreg(5'h1b, 16'h8001);
    rreg(5'h1b, 16'hff00, 16'h0000);
    err <= 1;
    repeat (2000) @(posedge clk);
    wreg(5'h1b, 16'h8001);
    rreg(5'h1b, 16'hff00, 16'hff00);
    $display("test self-test done");
    print_verdict();
  end
endmodule
`default_nettype wire
